// [hw/standby_mode_controller.sv]
// Standby controller: HALT, STOP, SNOOZE sequencing and clock gating
`timescale 1ns/10ps
`default_nettype none
`include "standby_defs.svh"

module standby_mode_controller #(
    parameter bit LARGE_VARIANT = 1'b0,
    parameter int STAB_CYCLES   = `SMC_STAB_CYCLES
) (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    // CPU core and instruction decoder
    input  wire logic                   halt_exec,
    input  wire logic                   stop_exec,
    input  wire logic                   irq_pending,
    // Clock configuration
    input  wire standby_pkg::clk_sel_t  cpu_clk_sel,
    input  wire standby_pkg::osc_t      osc_req,
    // Option and control bits
    input  wire logic                   watchdog_standby_option,
    input  wire logic                   watchdog_enable_option,
    input  wire logic                   watchdog_halt_stop_run_option,
    input  wire logic                   interval_timer_clock_select,
    input  wire logic                   rtc_low_power_control,
    // Snooze sources, snooze completion and the STOP address wake
    input  wire logic [1:0]             clocked_serial_snooze_en,
    input  wire logic [1:0]             clocked_serial_channel_rx,
    input  wire logic [1:0]             async_serial_snooze_en,
    input  wire logic [1:0]             async_serial_channel_rx,
    input  wire logic                   adc_snooze_en,
    input  wire logic                   rtc_interrupt_request,
    input  wire logic                   interval_timer_interrupt_request,
    input  wire logic                   snooze_done,
    input  wire logic                   snooze_irq,
    input  wire logic                   i2c_addr_match,
    // Mode and gating outputs
    output var  standby_pkg::mode_t     mode_r,
    output var  standby_pkg::osc_t      osc_en_r,
    output var  standby_pkg::clk_gate_t clk_en_r,
    output var  standby_pkg::periph_t   periph_en_r,
    output logic                        stab_busy_r,
    output logic                        wake_irq_r,
    output logic [1:0]                  snooze_src_r
);

    localparam logic [1:0] CH_MASK =
        LARGE_VARIANT ? `SMC_LARGE_CH_MASK : `SMC_SMALL_CH_MASK;
    localparam logic [`SMC_CNT_W-1:0] STAB_LAST =
        `SMC_CNT_W'(STAB_CYCLES - 1);

    // Elaboration check on the wait length
    if (STAB_CYCLES < 1 || STAB_CYCLES >= (1 << `SMC_CNT_W)) begin : g_chk
        $error("STAB_CYCLES out of range");
    end

    standby_pkg::mode_t     mode_nxt;
    standby_pkg::osc_t      osc_nxt;
    standby_pkg::clk_gate_t clk_nxt;
    standby_pkg::periph_t   per_nxt;
    logic [`SMC_CNT_W-1:0]  stab_cnt_r;
    logic                   ser_trig;
    logic                   adc_trig;
    logic                   snooze_ok;
    logic                   stop_wake;
    logic                   on_sub;
    logic                   standby;

    // Mode membership test used for gating
    function automatic logic in_mode(input standby_pkg::mode_t m,
                                     input logic [4:0] set);
        in_mode = |(m & set);
    endfunction

    // Wake and snooze triggers
    assign ser_trig  = |(CH_MASK &
        ((clocked_serial_snooze_en & clocked_serial_channel_rx) |
         (async_serial_snooze_en & async_serial_channel_rx)));
    assign adc_trig  = adc_snooze_en &
        (rtc_interrupt_request | interval_timer_interrupt_request);
    assign snooze_ok = cpu_clk_sel == standby_pkg::CLK_HOCO;
    assign stop_wake = irq_pending | i2c_addr_match;
    assign on_sub    = cpu_clk_sel == standby_pkg::CLK_SUB;

    // Next mode
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            standby_pkg::ST_RUN: begin
                if (stop_exec) begin
                    mode_nxt = standby_pkg::ST_STOP;
                end else if (halt_exec) begin
                    mode_nxt = standby_pkg::ST_HALT;
                end
            end
            standby_pkg::ST_HALT: begin
                if (irq_pending) begin
                    mode_nxt = standby_pkg::ST_RUN;
                end
            end
            standby_pkg::ST_STOP: begin
                if (stop_wake) begin
                    mode_nxt = (cpu_clk_sel == standby_pkg::CLK_CRYSTAL) ?
                        standby_pkg::ST_STAB :
                        standby_pkg::ST_RUN;
                end else if (snooze_ok && (ser_trig || adc_trig)) begin
                    mode_nxt = standby_pkg::ST_SNOOZE;
                end
            end
            standby_pkg::ST_STAB: begin
                if (stab_cnt_r == STAB_LAST) begin
                    mode_nxt = standby_pkg::ST_RUN;
                end
            end
            standby_pkg::ST_SNOOZE: begin
                if (snooze_done) begin
                    mode_nxt = snooze_irq ? standby_pkg::ST_RUN :
                                            standby_pkg::ST_STOP;
                end else if (irq_pending) begin
                    mode_nxt = standby_pkg::ST_RUN;
                end
            end
            default: mode_nxt = standby_pkg::ST_RUN;
        endcase
    end

    // Oscillator, clock gate and peripheral enables for the next mode
    always_comb begin
        standby = in_mode(mode_nxt, 5'h16);
        osc_nxt.hs_sys = in_mode(mode_nxt, 5'h0b) & osc_req.hs_sys;
        osc_nxt.hoco   = in_mode(mode_nxt, 5'h10) |
                         (in_mode(mode_nxt, 5'h0b) & osc_req.hoco);
        osc_nxt.sub    = osc_req.sub;
        osc_nxt.loco   = standby ?
            ((watchdog_enable_option & watchdog_standby_option) |
             interval_timer_clock_select) :
            (osc_req.loco | watchdog_enable_option |
             interval_timer_clock_select);
        clk_nxt.cpu    = mode_nxt == standby_pkg::ST_RUN;
        clk_nxt.sub    = osc_req.sub;
        clk_nxt.hs_sys = 1'b0;
        clk_nxt.hoco   = mode_nxt == standby_pkg::ST_SNOOZE;
        per_nxt = '0;
        per_nxt.wdt = watchdog_enable_option &
            (!standby || watchdog_halt_stop_run_option);
        case (mode_nxt)
            standby_pkg::ST_RUN: begin
                clk_nxt.hs_sys = osc_req.hs_sys;
                clk_nxt.hoco   = osc_req.hoco;
                per_nxt.tau    = 1'b1;
                per_nxt.serial_array_unit    = 1'b1;
                per_nxt.i2c    = 1'b1;
                per_nxt.adc    = 1'b1;
                per_nxt.itmr   = 1'b1;
            end
            standby_pkg::ST_HALT: begin
                clk_nxt.hs_sys = cpu_clk_sel == standby_pkg::CLK_CRYSTAL ||
                                 cpu_clk_sel == standby_pkg::CLK_EXT;
                clk_nxt.hoco   = snooze_ok;
                per_nxt.tau    = !(on_sub && rtc_low_power_control);
                per_nxt.serial_array_unit    = !(on_sub && rtc_low_power_control);
                per_nxt.i2c    = !on_sub;
                per_nxt.adc    = !on_sub;
                per_nxt.itmr   = 1'b1;
            end
            standby_pkg::ST_STOP, standby_pkg::ST_STAB: begin
                per_nxt.i2c    = 1'b1;
                per_nxt.itmr   = 1'b1;
            end
            standby_pkg::ST_SNOOZE: begin
                per_nxt.serial_array_unit    = ser_trig | snooze_src_r[0];
                per_nxt.adc    = adc_trig | snooze_src_r[1];
                per_nxt.i2c    = 1'b1;
                per_nxt.itmr   = 1'b1;
            end
            default: begin
                clk_nxt.hoco   = 1'b0;
            end
        endcase
    end

    // Mode register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= standby_pkg::ST_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Registered gating outputs
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            osc_en_r    <= 4'h0;
            clk_en_r    <= 4'h8;
            periph_en_r <= 6'h00;
        end else begin
            osc_en_r    <= osc_nxt;
            clk_en_r    <= clk_nxt;
            periph_en_r <= per_nxt;
        end
    end

    // Oscillation stabilization counter
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stab_cnt_r  <= '0;
            stab_busy_r <= 1'b0;
        end else begin
            stab_busy_r <= mode_nxt == standby_pkg::ST_STAB;
            if (mode_r == standby_pkg::ST_STAB) begin
                stab_cnt_r <= stab_cnt_r + `SMC_CNT_W'(1);
            end else begin
                stab_cnt_r <= '0;
            end
        end
    end

    // Snooze source capture and completion interrupt
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            snooze_src_r <= 2'h0;
            wake_irq_r   <= 1'b0;
        end else begin
            wake_irq_r <= mode_r == standby_pkg::ST_SNOOZE &&
                          snooze_done && snooze_irq;
            if (mode_nxt != standby_pkg::ST_SNOOZE) begin
                snooze_src_r <= 2'h0;
            end else if (mode_r == standby_pkg::ST_STOP) begin
                snooze_src_r <= {adc_trig, ser_trig};
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence xtal_wake_s;
        mode_r == standby_pkg::ST_STOP && stop_wake &&
        cpu_clk_sel == standby_pkg::CLK_CRYSTAL;
    endsequence
    sequence held_in_wait_s;
        (mode_r == standby_pkg::ST_STAB && !clk_en_r.cpu) [*2];
    endsequence

    halt_entry_a: assert property (
        mode_r == standby_pkg::ST_RUN && halt_exec && !stop_exec |=>
        mode_r == standby_pkg::ST_HALT && !clk_en_r.cpu)
        else $error("HALT not entered");
    halt_osc_a: assert property (
        mode_r == standby_pkg::ST_HALT |->
        osc_en_r.hoco == $past(osc_req.hoco) &&
        osc_en_r.hs_sys == $past(osc_req.hs_sys))
        else $error("Oscillator stopped in HALT");
    halt_release_a: assert property (
        mode_r == standby_pkg::ST_HALT && irq_pending |=>
        mode_r == standby_pkg::ST_RUN && clk_en_r.cpu)
        else $error("HALT release delayed");
    stop_osc_off_a: assert property (
        mode_r == standby_pkg::ST_STOP |->
        !osc_en_r.hs_sys && !osc_en_r.hoco && !clk_en_r.cpu)
        else $error("Oscillator running in STOP");
    stop_wake_a: assert property (
        mode_r == standby_pkg::ST_STOP && stop_wake &&
        cpu_clk_sel != standby_pkg::CLK_CRYSTAL |=>
        mode_r == standby_pkg::ST_RUN)
        else $error("STOP not released");
    stab_wait_a: assert property (
        xtal_wake_s |=> held_in_wait_s)
        else $error("No stabilization wait");
    stab_len_a: assert property (
        mode_r == standby_pkg::ST_RUN &&
        $past(mode_r) == standby_pkg::ST_STAB |->
        $past(stab_cnt_r) == STAB_LAST)
        else $error("Stabilization wait length wrong");
    snooze_entry_a: assert property (
        mode_r == standby_pkg::ST_STOP && !stop_wake && snooze_ok &&
        (ser_trig || adc_trig) |=> mode_r == standby_pkg::ST_SNOOZE &&
        !clk_en_r.cpu && osc_en_r.hoco)
        else $error("SNOOZE not entered");
    snooze_clk_a: assert property (
        $rose(mode_r == standby_pkg::ST_SNOOZE) |->
        $past(cpu_clk_sel) == standby_pkg::CLK_HOCO)
        else $error("SNOOZE without on-chip clock");
    snooze_chan_a: assert property (
        mode_r == standby_pkg::ST_STOP && !stop_wake && !adc_trig &&
        !(|(CH_MASK & (clocked_serial_channel_rx |
                       async_serial_channel_rx))) |=>
        mode_r != standby_pkg::ST_SNOOZE)
        else $error("SNOOZE from unsupported source");
    halt_main_a: assert property (
        mode_r == standby_pkg::ST_HALT &&
        $past(cpu_clk_sel) == standby_pkg::CLK_HOCO |->
        clk_en_r.hoco && !clk_en_r.hs_sys)
        else $error("Main clock gating wrong in HALT");
    sub_keep_a: assert property (
        $past(rstn) |-> osc_en_r.sub == $past(osc_req.sub))
        else $error("Subsystem clock state changed");
    loco_stby_a: assert property (
        mode_r == standby_pkg::ST_STOP |-> osc_en_r.loco ==
        $past((watchdog_enable_option && watchdog_standby_option) ||
              interval_timer_clock_select))
        else $error("Low-speed oscillator wrong");
    wdt_stby_a: assert property (
        mode_r == standby_pkg::ST_HALT |-> periph_en_r.wdt ==
        $past(watchdog_enable_option && watchdog_halt_stop_run_option))
        else $error("Watchdog standby run wrong");
    halt_sub_a: assert property (
        mode_r == standby_pkg::ST_HALT &&
        $past(cpu_clk_sel) == standby_pkg::CLK_SUB |->
        periph_en_r.tau == !$past(rtc_low_power_control) &&
        periph_en_r.serial_array_unit == !$past(rtc_low_power_control) &&
        !periph_en_r.i2c && !periph_en_r.adc && periph_en_r.itmr &&
        !clk_en_r.hs_sys && !clk_en_r.hoco)
        else $error("Subclock HALT peripheral gating wrong");
    stop_periph_a: assert property (
        mode_r == standby_pkg::ST_STOP |->
        !periph_en_r.tau && periph_en_r.itmr && periph_en_r.i2c)
        else $error("STOP peripheral gating wrong");
    snooze_done_a: assert property (
        mode_r == standby_pkg::ST_SNOOZE && snooze_done |=>
        ($past(snooze_irq) ? (mode_r == standby_pkg::ST_RUN && wake_irq_r)
                    : mode_r == standby_pkg::ST_STOP) [*1] ##1
        !wake_irq_r)
        else $error("SNOOZE completion wrong");

endmodule
`default_nettype wire

// [hw/standby_defs.svh]
// Timing constants and channel masks for the standby mode controller
`ifndef STANDBY_DEFS_SVH
`define STANDBY_DEFS_SVH

// Clock period and oscillation stabilization wait
`define SMC_CLK_PERIOD_NS 20
`define SMC_STAB_TIME_NS  10000
`define SMC_STAB_CYCLES   \
    ((`SMC_STAB_TIME_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS)
`define SMC_CNT_W         16

// Snooze capable serial channels (bit 0: channel 00/0, bit 1: 20/2)
`define SMC_SMALL_CH_MASK 2'h1
`define SMC_LARGE_CH_MASK 2'h3

`endif

// [hw/standby_pkg.sv]
// Types shared by the standby mode controller
package standby_pkg;

    // Operating mode, one-hot
    typedef enum logic [4:0] {
        ST_RUN    = 5'h01,
        ST_HALT   = 5'h02,
        ST_STOP   = 5'h04,
        ST_STAB   = 5'h08,
        ST_SNOOZE = 5'h10
    } mode_t;

    // Source of the CPU/peripheral hardware clock
    typedef enum logic [1:0] {
        CLK_HOCO    = 2'h0,
        CLK_CRYSTAL = 2'h1,
        CLK_EXT     = 2'h2,
        CLK_SUB     = 2'h3
    } clk_sel_t;

    // Oscillator run requests and enables
    typedef struct packed {
        logic hs_sys;
        logic hoco;
        logic sub;
        logic loco;
    } osc_t;

    // Clock supply gates
    typedef struct packed {
        logic cpu;
        logic hs_sys;
        logic hoco;
        logic sub;
    } clk_gate_t;

    // Peripheral operation enables
    typedef struct packed {
        logic tau;
        logic serial_array_unit;
        logic i2c;
        logic adc;
        logic itmr;
        logic wdt;
    } periph_t;

endpackage

// [sim/snooze_peer.sv]
// Peripheral model that finishes a snooze transfer a few cycles in
`timescale 1ns/10ps
`default_nettype none
module snooze_peer #(
    parameter int DELAY = 3
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    // Controller side
    input  wire standby_pkg::mode_t mode_r,
    input  wire logic               irq_on_done,
    output logic                    snooze_done,
    output logic                    snooze_irq
);
    int cnt;

    // Completion pulse; the condition line wanders when not qualified
    always @(negedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 0;
            snooze_done <= 1'b0;
            snooze_irq <= 1'b0;
        end else if (mode_r == standby_pkg::ST_SNOOZE && cnt == DELAY) begin
            cnt <= 0;
            snooze_done <= 1'b1;
            snooze_irq <= irq_on_done;
        end else begin
            cnt <= (mode_r == standby_pkg::ST_SNOOZE) ? cnt + 1 : 0;
            snooze_done <= 1'b0;
            snooze_irq <= ~snooze_irq;
        end
    end
endmodule
`default_nettype wire

// [sim/standby_mode_controller_tb.sv]
// Self-checking bench for the standby mode controller
`timescale 1ns/10ps
`default_nettype none
module standby_mode_controller_tb;
    localparam int STAB = 4;
    logic ref_clk = 1'b0, rstn = 1'b0, halt_exec = 1'b0, stop_exec = 1'b0;
    logic irq_pending = 1'b0, i2c_addr_match = 1'b0, peer_irq = 1'b0;
    standby_pkg::clk_sel_t cpu_clk_sel = standby_pkg::CLK_HOCO;
    standby_pkg::osc_t     osc_req = 4'he;
    logic watchdog_standby_option = 1'b1, watchdog_enable_option = 1'b1;
    logic watchdog_halt_stop_run_option = 1'b0;
    logic interval_timer_clock_select = 1'b0, rtc_low_power_control = 1'b0;
    logic [1:0] clocked_serial_snooze_en = 2'h0;
    logic [1:0] clocked_serial_channel_rx = 2'h0;
    logic [1:0] async_serial_snooze_en = 2'h0, async_serial_channel_rx = 2'h0;
    logic adc_snooze_en = 1'b0, rtc_interrupt_request = 1'b0;
    logic interval_timer_interrupt_request = 1'b0;
    logic snooze_done, snooze_irq, stab_busy_r, wake_irq_r;
    logic [1:0] snooze_src_r;
    standby_pkg::mode_t     mode_r;
    standby_pkg::osc_t      osc_en_r;
    standby_pkg::clk_gate_t clk_en_r;
    standby_pkg::periph_t   periph_en_r;
    int miscompares = 0, total_checks = 0;

    // Clock, 20 ns period
    always #10 ref_clk = ~ref_clk;

    standby_mode_controller #(.LARGE_VARIANT(1'b0), .STAB_CYCLES(STAB)) dut (
        .ref_clk, .rstn, .halt_exec, .stop_exec, .irq_pending, .cpu_clk_sel,
        .osc_req, .watchdog_standby_option, .watchdog_enable_option,
        .watchdog_halt_stop_run_option, .interval_timer_clock_select,
        .rtc_low_power_control, .clocked_serial_snooze_en,
        .clocked_serial_channel_rx, .async_serial_snooze_en,
        .async_serial_channel_rx, .adc_snooze_en, .rtc_interrupt_request,
        .interval_timer_interrupt_request, .snooze_done, .snooze_irq,
        .i2c_addr_match, .mode_r, .osc_en_r, .clk_en_r, .periph_en_r,
        .stab_busy_r, .wake_irq_r, .snooze_src_r);

    snooze_peer #(.DELAY(3)) peer (
        .ref_clk, .rstn, .mode_r, .irq_on_done(peer_irq), .snooze_done,
        .snooze_irq);

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report;
        if (miscompares == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Bounded wait for a mode, then compare
    task automatic wait_mode(input standby_pkg::mode_t m, input string nm);
        int n;
        n = 0;
        while (mode_r !== m && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        chk(nm, m, mode_r);
    endtask

    // One-cycle decoder pulses
    task automatic do_halt;
        halt_exec = 1'b1;
        @(negedge ref_clk);
        halt_exec = 1'b0;
    endtask

    task automatic do_stop;
        stop_exec = 1'b1;
        @(negedge ref_clk);
        stop_exec = 1'b0;
    endtask

    task automatic do_irq;
        irq_pending = 1'b1;
        @(negedge ref_clk);
        irq_pending = 1'b0;
    endtask

    // Receive start on channel set v of serial kind k
    task automatic serial_rx(input int k, input logic [1:0] v);
        clocked_serial_channel_rx = (k == 0) ? v : 2'h0;
        async_serial_channel_rx = (k == 1) ? v : 2'h0;
        @(negedge ref_clk);
        clocked_serial_channel_rx = 2'h0;
        async_serial_channel_rx = 2'h0;
    endtask

    // HALT from the on-chip oscillator
    task automatic halt_main;
        do_halt();
        chk("halt mode", standby_pkg::ST_HALT, mode_r);
        chk("halt cpu gate", 8'h00, clk_en_r.cpu);
        chk("halt osc", 8'h07, osc_en_r[3:1]);
        chk("halt main gates", 8'h01, {clk_en_r.hs_sys, clk_en_r.hoco});
        chk("halt wdt", 8'h00, periph_en_r.wdt);
        chk("halt loco", 8'h01, osc_en_r.loco);
        do_irq();
        chk("halt release", standby_pkg::ST_RUN, mode_r);
        chk("halt release cpu", 8'h01, clk_en_r.cpu);
        // External main clock selected: of the main gates only the main system gate stays
        cpu_clk_sel = standby_pkg::CLK_EXT;
        do_halt();
        chk("halt ext gates", 8'h02, clk_en_r[2:1]);
        do_irq();
        cpu_clk_sel = standby_pkg::CLK_HOCO;
    endtask

    // HALT from the subsystem clock with both rtc settings
    task automatic halt_sub;
        cpu_clk_sel = standby_pkg::CLK_SUB;
        watchdog_halt_stop_run_option = 1'b1;
        rtc_low_power_control = 1'b1;
        do_halt();
        chk("sub gates", 8'h01, clk_en_r);
        chk("sub periph lp", 8'h03, periph_en_r);
        do_irq();
        rtc_low_power_control = 1'b0;
        do_halt();
        chk("sub periph", 8'h33, periph_en_r);
        do_irq();
        watchdog_halt_stop_run_option = 1'b0;
        cpu_clk_sel = standby_pkg::CLK_HOCO;
    endtask

    // STOP on the crystal: snooze refused, stabilization wait on release
    task automatic stop_crystal;
        int n;
        cpu_clk_sel = standby_pkg::CLK_CRYSTAL;
        clocked_serial_snooze_en = 2'h1;
        do_stop();
        chk("stop mode", standby_pkg::ST_STOP, mode_r);
        chk("stop osc", 8'h00, {osc_en_r.hs_sys, osc_en_r.hoco});
        chk("stop timers", 8'h01, {periph_en_r.tau, periph_en_r.itmr});
        serial_rx(0, 2'h1);
        chk("snooze on crystal", standby_pkg::ST_STOP, mode_r);
        do_irq();
        chk("stab mode", standby_pkg::ST_STAB, mode_r);
        n = 0;
        while (stab_busy_r === 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        chk("stab length", STAB, n);
        chk("stop release", standby_pkg::ST_RUN, mode_r);
        clocked_serial_snooze_en = 2'h0;
        cpu_clk_sel = standby_pkg::CLK_HOCO;
    endtask

    // Serial snooze ending in a wake interrupt, both serial kinds
    task automatic snooze_serial;
        peer_irq = 1'b1;
        clocked_serial_snooze_en = 2'h3;
        async_serial_snooze_en = 2'h3;
        for (int k = 0; k < 2; k++) begin
            do_stop();
            serial_rx(k, 2'h2);
            chk("snooze ch2 small", standby_pkg::ST_STOP, mode_r);
            serial_rx(k, 2'h1);
            chk("snooze entry", standby_pkg::ST_SNOOZE, mode_r);
            chk("snooze src", 8'h01, snooze_src_r);
            chk("snooze gates", 8'h03,
                {clk_en_r.cpu, clk_en_r.hoco, periph_en_r.serial_array_unit});
            wait_mode(standby_pkg::ST_RUN, "snooze wake");
            chk("wake irq", 8'h01, wake_irq_r);
            @(negedge ref_clk);
            chk("wake irq end", 8'h00, wake_irq_r);
        end
        clocked_serial_snooze_en = 2'h0;
        async_serial_snooze_en = 2'h0;
    endtask

    // Timer triggered conversions returning to STOP, then address wake
    task automatic snooze_adc;
        peer_irq = 1'b0;
        adc_snooze_en = 1'b1;
        do_stop();
        for (int k = 0; k < 2; k++) begin
            rtc_interrupt_request = (k == 0);
            interval_timer_interrupt_request = (k == 1);
            @(negedge ref_clk);
            rtc_interrupt_request = 1'b0;
            interval_timer_interrupt_request = 1'b0;
            chk("adc snooze", standby_pkg::ST_SNOOZE, mode_r);
            chk("adc src", 8'h02, snooze_src_r);
            chk("adc enable", 8'h01, periph_en_r.adc);
            wait_mode(standby_pkg::ST_STOP, "adc back to stop");
        end
        i2c_addr_match = 1'b1;
        @(negedge ref_clk);
        i2c_addr_match = 1'b0;
        chk("address wake", standby_pkg::ST_RUN, mode_r);
        adc_snooze_en = 1'b0;
    endtask

    // Watchdog on a hang
    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        final_report();
    end

    // Main sequence
    initial begin
        repeat (10) @(negedge ref_clk);
        chk("reset mode", standby_pkg::ST_RUN, mode_r);
        chk("reset gates", 8'h08, clk_en_r);
        rstn = 1'b1;
        @(negedge ref_clk);
        halt_main();
        halt_sub();
        stop_crystal();
        snooze_serial();
        snooze_adc();
        final_report();
    end
endmodule
`default_nettype wire
